// ---- core/prf_params.svh ----
// Offsets, field positions, reset values and fixed-point scales of the raster front end.
// Assumes the including file also imports prf_pkg for the types.
`ifndef PRF_PARAMS_SVH
`define PRF_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PRF_OFF_CTRL 8'h00
`define PRF_OFF_STATUS 8'h04
`define PRF_OFF_MASK_ROW 8'h08
`define PRF_OFF_MASK_DATA 8'h0C

// ****************************************
// Control fields and reset values
// ****************************************
`define PRF_CTRL_CW 0
`define PRF_CTRL_CULL_EN 1
`define PRF_CTRL_SEL_LO 2
`define PRF_CTRL_SEL_HI 3
`define PRF_CTRL_STIP_EN 4
`define PRF_CTRL_AA_EN 5
`define PRF_CULL_SEL_RESET 2'h2
`define PRF_ROW_ONES 32'hFFFF_FFFF
`define PRF_RESP_OKAY 2'h0
`define PRF_RESP_SLVERR 2'h2

// ****************************************
// Fixed point
// ****************************************
`define PRF_PIX_CENTER 18'h0_0008
`define PRF_SAMPLE_OFF 18'h0_0004
`define PRF_EXT_SHIFT 3
`define PRF_RCP_SHIFT 24
`define PRF_ONE_FX 41'h100_0000
`define PRF_W_MIN 16'h0001
`define PRF_COV_FULL 3'h4
`define PRF_COV_MIN 3'h1

`endif

// ---- core/prf_pkg.sv ----
// Types shared by the raster front end and its area mask store.
// Assumes window coordinates in 12.4 unsigned-range fixed point.
package prf_pkg;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [2:0] {
		PRF_ST_IDLE = 3'h1,
		PRF_ST_SETUP = 3'h2,
		PRF_ST_SCAN = 3'h4
	} prf_state_t;

	typedef enum logic [1:0] {
		PRF_CULL_FRONT = 2'h1,
		PRF_CULL_BACK = 2'h2,
		PRF_CULL_BOTH = 2'h3
	} prf_cull_t;

	typedef enum logic [1:0] {
		PRF_Q_PERSP = 2'h0,
		PRF_Q_LINEAR = 2'h1,
		PRF_Q_FLAT = 2'h2
	} prf_qual_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic [15:0] z;
		logic [15:0] w;
		logic [15:0] f;
	} prf_vtx_t;

	typedef struct packed {
		prf_vtx_t [2:0] v;
		prf_qual_t qual;
		logic [1:0] provoke;
	} prf_prim_t;

	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic [15:0] z;
		logic [15:0] f;
		logic [2:0] cov;
		logic front;
	} prf_frag_t;

endpackage : prf_pkg

// ---- core/prf_area_mask.sv ----
// 32x32 area mask store, one 32-bit row per window y modulo 32.
// Assumes a single writer; both read ports are combinational.
`include "prf_params.svh"

module prf_area_mask
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Row load
	input wire logic wr_en,
	input wire logic [4:0] wr_row,
	input wire logic [31:0] wr_data,
	// Bus readback
	input wire logic [4:0] bus_row,
	output logic [31:0] bus_data,
	// Pixel lookup
	input wire logic [4:0] pix_row,
	output logic [31:0] pix_data
);
	import prf_pkg::*;

	logic [31:0] rows_r [32];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < 32; i++)
				rows_r[i] <= `PRF_ROW_ONES;
		end
		else if (wr_en)
			rows_r[wr_row] <= wr_data;
	end

	assign bus_data = rows_r[bus_row];
	assign pix_data = rows_r[pix_row];

endmodule : prf_area_mask

// ---- core/prf_raster_front_end.sv ----
// Polygon raster front end: facing, culling, coverage, interpolation, area mask.
// Assumes clipped triangles in window space (polygons fan-split upstream with a
// common first vertex), an AXI4-Lite master, and a downstream stage on sys_clk.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`include "prf_params.svh"

module prf_raster_front_end
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Primitive stream in
	input wire prf_pkg::prf_prim_t prim_in,
	input wire logic prim_valid,
	output logic prim_ready,
	// Fragment stream out
	output prf_pkg::prf_frag_t frag_out,
	output logic frag_valid,
	input wire logic frag_ready
);
	import prf_pkg::*;

	function automatic logic [31:0] prf_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				m[b*8 +: 8] = nw[b*8 +: 8];
		return m;
	endfunction : prf_merge

	function automatic logic signed [35:0] prf_edge(input prf_vtx_t a, input prf_vtx_t b,
		input logic signed [17:0] sx, input logic signed [17:0] sy);
		logic signed [17:0] dx;
		logic signed [17:0] dy;
		dx = 18'(b.x) - 18'(a.x);
		dy = 18'(b.y) - 18'(a.y);
		return 36'(dx * (sy - 18'(a.y)) - dy * (sx - 18'(a.x)));
	endfunction : prf_edge

	// ****************************************
	// Control registers
	// ****************************************
	logic wind_cw_r;
	logic cull_en_r;
	prf_cull_t cull_sel_r;
	logic stip_en_r;
	logic aa_en_r;
	logic [4:0] mask_row_r;
	logic last_front_r;
	logic last_culled_r;
	logic [31:0] ctrl_rd;
	logic [31:0] ctrl_m;
	logic [31:0] status_rd;
	logic [31:0] mask_bus_row;
	logic [31:0] mask_pix_row;
	logic [31:0] mask_wdata;
	logic mask_we;

	logic aw_rdy_r;
	logic w_rdy_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_wr;
	logic ar_rdy_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	prf_state_t state_r;
	prf_prim_t prim_r;
	logic prim_rdy_r;
	logic [11:0] cur_x_r;
	logic [11:0] cur_y_r;
	logic [11:0] xmin_r;
	logic [11:0] xmax_r;
	logic [11:0] ymax_r;
	logic neg_r;
	logic front_r;
	logic signed [35:0] area_r;
	logic [2:0] own_r;
	logic signed [35:0] ext_r [3];
	logic signed [40:0] rcp_r [3];
	logic signed [40:0] fw_r [3];
	prf_frag_t frag_r;
	logic frag_valid_r;

	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd[`PRF_CTRL_CW] = wind_cw_r;
		ctrl_rd[`PRF_CTRL_CULL_EN] = cull_en_r;
		ctrl_rd[`PRF_CTRL_SEL_HI:`PRF_CTRL_SEL_LO] = cull_sel_r;
		ctrl_rd[`PRF_CTRL_STIP_EN] = stip_en_r;
		ctrl_rd[`PRF_CTRL_AA_EN] = aa_en_r;
		ctrl_m = prf_merge(ctrl_rd, wdata_r, wstrb_r);
		status_rd = {29'h0, last_culled_r, last_front_r, state_r != PRF_ST_IDLE};
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wind_cw_r <= 1'b0;
			cull_en_r <= 1'b0;
			cull_sel_r <= prf_cull_t'(`PRF_CULL_SEL_RESET);
			stip_en_r <= 1'b0;
			aa_en_r <= 1'b0;
			mask_row_r <= '0;
		end
		else if (do_wr && awaddr_r == `PRF_OFF_CTRL)
		begin
			wind_cw_r <= ctrl_m[`PRF_CTRL_CW];
			cull_en_r <= ctrl_m[`PRF_CTRL_CULL_EN];
			cull_sel_r <= prf_cull_t'(ctrl_m[`PRF_CTRL_SEL_HI:`PRF_CTRL_SEL_LO]);
			stip_en_r <= ctrl_m[`PRF_CTRL_STIP_EN];
			aa_en_r <= ctrl_m[`PRF_CTRL_AA_EN];
		end
		else if (do_wr && awaddr_r == `PRF_OFF_MASK_ROW && wstrb_r[0])
			mask_row_r <= wdata_r[4:0];
	end

	// Raw bits go straight in; byte enables keep the untouched lanes of the row
	assign mask_we = do_wr && awaddr_r == `PRF_OFF_MASK_DATA;
	assign mask_wdata = prf_merge(mask_bus_row, wdata_r, wstrb_r);

	prf_area_mask u_mask (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.wr_en(mask_we),
		.wr_row(mask_row_r),
		.wr_data(mask_wdata),
		.bus_row(mask_row_r),
		.bus_data(mask_bus_row),
		.pix_row(cur_y_r[4:0]),
		.pix_data(mask_pix_row)
	);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign do_wr = !aw_rdy_r && !w_rdy_r && !bvalid_r;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= `PRF_RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else
		begin
			if (s_axi_awvalid && aw_rdy_r)
			begin
				aw_rdy_r <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && w_rdy_r)
			begin
				w_rdy_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				bvalid_r <= 1'b1;
				if (awaddr_r == `PRF_OFF_CTRL || awaddr_r == `PRF_OFF_STATUS ||
					awaddr_r == `PRF_OFF_MASK_ROW || awaddr_r == `PRF_OFF_MASK_DATA)
					bresp_r <= `PRF_RESP_OKAY;
				else
					bresp_r <= `PRF_RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
			begin
				bvalid_r <= 1'b0;
				aw_rdy_r <= 1'b1;
				w_rdy_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ar_rdy_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= `PRF_RESP_OKAY;
			rdata_r <= '0;
		end
		else if (s_axi_arvalid && ar_rdy_r)
		begin
			ar_rdy_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= `PRF_RESP_OKAY;
			if (s_axi_araddr == `PRF_OFF_CTRL)
				rdata_r <= ctrl_rd;
			else if (s_axi_araddr == `PRF_OFF_STATUS)
				rdata_r <= status_rd;
			else if (s_axi_araddr == `PRF_OFF_MASK_ROW)
				rdata_r <= {27'h0, mask_row_r};
			else if (s_axi_araddr == `PRF_OFF_MASK_DATA)
				rdata_r <= mask_bus_row;
			else
			begin
				rdata_r <= '0;
				rresp_r <= `PRF_RESP_SLVERR;
			end
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r <= 1'b0;
			ar_rdy_r <= 1'b1;
		end
	end

	// ****************************************
	// Setup: area, facing, culling, edge data
	// ****************************************
	logic signed [35:0] area2;
	logic front_nxt;
	logic keep_nxt;
	logic signed [17:0] sdx;
	logic signed [17:0] sdy;
	logic [2:0] own_nxt;
	logic signed [35:0] ext_nxt [3];
	logic [15:0] wq [3];

	always_comb
	begin
		sdx = '0;
		sdy = '0;
		// Twice the signed area, unclipped or clipped alike
		area2 = prf_edge(prim_r.v[0], prim_r.v[1], 18'(prim_r.v[2].x), 18'(prim_r.v[2].y));
		front_nxt = wind_cw_r ? (area2 < 0) : (area2 > 0);
		keep_nxt = area2 != 0 && (!cull_en_r ||
			(front_nxt ? cull_sel_r == PRF_CULL_BACK : cull_sel_r == PRF_CULL_FRONT));
		for (int i = 0; i < 3; i++)
		begin
			// A zero w would divide by zero; treat it as the smallest step
			wq[i] = prim_r.v[i].w == 0 ? `PRF_W_MIN : prim_r.v[i].w;
			sdx = 18'(prim_r.v[(i + 1) % 3].x) - 18'(prim_r.v[i].x);
			sdy = 18'(prim_r.v[(i + 1) % 3].y) - 18'(prim_r.v[i].y);
			if (area2 < 0)
			begin
				sdx = -sdx;
				sdy = -sdy;
			end
			// Antisymmetric owner test: a shared edge runs opposite ways in its two triangles
			own_nxt[i] = sdy > 0 || (sdy == 0 && sdx > 0);
			ext_nxt[i] = 36'((sdx < 0 ? -sdx : sdx) + (sdy < 0 ? -sdy : sdy)) <<< `PRF_EXT_SHIFT;
		end
	end

	// ****************************************
	// Scan: coverage and mask
	// ****************************************
	logic signed [17:0] cx;
	logic signed [17:0] cy;
	logic signed [35:0] ec [3];
	logic signed [35:0] es;
	logic in_ctr;
	logic aa_hit;
	logic cover_hit;
	logic stip_bit;
	logic advance;
	logic issue;
	logic [2:0] cnt;
	logic smp_ok;

	always_comb
	begin
		cx = 18'({cur_x_r, 4'h0}) + `PRF_PIX_CENTER;
		cy = 18'({cur_y_r, 4'h0}) + `PRF_PIX_CENTER;
		in_ctr = 1'b1;
		aa_hit = 1'b1;
		cnt = '0;
		es = '0;
		smp_ok = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			ec[i] = prf_edge(prim_r.v[i], prim_r.v[(i + 1) % 3], cx, cy);
			if (neg_r)
				ec[i] = -ec[i];
			if (!(ec[i] > 0 || (ec[i] == 0 && own_r[i])))
				in_ctr = 1'b0;
			if (ec[i] + ext_r[i] <= 0)
				aa_hit = 1'b0;
		end
		for (int s = 0; s < 4; s++)
		begin
			smp_ok = 1'b1;
			for (int i = 0; i < 3; i++)
			begin
				es = prf_edge(prim_r.v[i], prim_r.v[(i + 1) % 3],
					s[0] ? cx + `PRF_SAMPLE_OFF : cx - `PRF_SAMPLE_OFF,
					s[1] ? cy + `PRF_SAMPLE_OFF : cy - `PRF_SAMPLE_OFF);
				if (neg_r ? es > 0 : es < 0)
					smp_ok = 1'b0;
			end
			cnt = cnt + 3'(smp_ok);
		end
	end

	assign cover_hit = aa_en_r ? aa_hit : in_ctr;
	// Same gate whatever the antialias setting
	assign stip_bit = mask_pix_row[cur_x_r[4:0]];
	assign advance = state_r == PRF_ST_SCAN && (!frag_valid_r || frag_ready);
	assign issue = advance && cover_hit && (!stip_en_r || stip_bit);

	// ****************************************
	// Interpolation
	// ****************************************
	logic signed [79:0] num;
	logic signed [79:0] den;
	logic signed [79:0] lin;
	logic signed [79:0] zs;
	logic [15:0] f_out;
	logic [15:0] z_out;
	logic [1:0] pv;

	always_comb
	begin
		num = '0;
		den = '0;
		lin = '0;
		zs = '0;
		// Vertex k weight is the edge opposite it; fans give convex weights per triangle
		for (int k = 0; k < 3; k++)
		begin
			num = num + 80'(ec[(k + 1) % 3]) * 80'(fw_r[k]);
			den = den + 80'(ec[(k + 1) % 3]) * 80'(rcp_r[k]);
			lin = lin + 80'(ec[(k + 1) % 3]) * 80'({1'b0, prim_r.v[k].f});
			zs = zs + 80'(ec[(k + 1) % 3]) * 80'({1'b0, prim_r.v[k].z});
		end
		pv = prim_r.provoke > 2'h2 ? 2'h2 : prim_r.provoke;
		z_out = 16'(zs / 80'(area_r));
		// Centre sample stands in for the area integral on partial squares
		if (prim_r.qual == PRF_Q_FLAT)
			f_out = prim_r.v[pv].f;
		else if (prim_r.qual == PRF_Q_LINEAR)
			f_out = 16'(lin / 80'(area_r));
		else if (den != 0)
			f_out = 16'(num / den);
		else
			f_out = prim_r.v[pv].f;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= PRF_ST_IDLE;
			prim_r <= '0;
			prim_rdy_r <= 1'b1;
			cur_x_r <= '0;
			cur_y_r <= '0;
			xmin_r <= '0;
			xmax_r <= '0;
			ymax_r <= '0;
			neg_r <= 1'b0;
			front_r <= 1'b0;
			area_r <= '0;
			own_r <= '0;
			last_front_r <= 1'b0;
			last_culled_r <= 1'b0;
			for (int k = 0; k < 3; k++)
			begin
				ext_r[k] <= '0;
				rcp_r[k] <= '0;
				fw_r[k] <= '0;
			end
		end
		else
		begin
			case (state_r)
				PRF_ST_IDLE:
				begin
					if (prim_valid && prim_rdy_r)
					begin
						prim_r <= prim_in;
						prim_rdy_r <= 1'b0;
						state_r <= PRF_ST_SETUP;
					end
				end
				PRF_ST_SETUP:
				begin
					neg_r <= area2 < 0;
					area_r <= area2 < 0 ? -area2 : area2;
					own_r <= own_nxt;
					front_r <= front_nxt;
					last_front_r <= front_nxt;
					last_culled_r <= !keep_nxt;
					xmin_r <= 12'(prim_r.v[0].x >>> 4);
					xmax_r <= 12'(prim_r.v[0].x >>> 4);
					ymax_r <= 12'(prim_r.v[0].y >>> 4);
					cur_x_r <= 12'(prim_r.v[0].x >>> 4);
					cur_y_r <= 12'(prim_r.v[0].y >>> 4);
					for (int k = 0; k < 3; k++)
					begin
						ext_r[k] <= ext_nxt[k];
						rcp_r[k] <= `PRF_ONE_FX / 41'(wq[k]);
						fw_r[k] <= 41'({prim_r.v[k].f, 24'h00_0000}) / 41'(wq[k]);
						if (prim_r.v[k].x[15:4] < prim_r.v[0].x[15:4])
							xmin_r <= prim_r.v[k].x[15:4];
					end
					// Bounding box over all three vertices
					xmin_r <= prf_min3(prim_r.v[0].x[15:4], prim_r.v[1].x[15:4], prim_r.v[2].x[15:4]);
					cur_x_r <= prf_min3(prim_r.v[0].x[15:4], prim_r.v[1].x[15:4], prim_r.v[2].x[15:4]);
					cur_y_r <= prf_min3(prim_r.v[0].y[15:4], prim_r.v[1].y[15:4], prim_r.v[2].y[15:4]);
					xmax_r <= ~prf_min3(~prim_r.v[0].x[15:4], ~prim_r.v[1].x[15:4], ~prim_r.v[2].x[15:4]);
					ymax_r <= ~prf_min3(~prim_r.v[0].y[15:4], ~prim_r.v[1].y[15:4], ~prim_r.v[2].y[15:4]);
					if (keep_nxt)
						state_r <= PRF_ST_SCAN;
					else
					begin
						prim_rdy_r <= 1'b1;
						state_r <= PRF_ST_IDLE;
					end
				end
				PRF_ST_SCAN:
				begin
					if (advance)
					begin
						if (cur_x_r != xmax_r)
							cur_x_r <= cur_x_r + 12'h001;
						else if (cur_y_r != ymax_r)
						begin
							cur_x_r <= xmin_r;
							cur_y_r <= cur_y_r + 12'h001;
						end
						else
						begin
							prim_rdy_r <= 1'b1;
							state_r <= PRF_ST_IDLE;
						end
					end
				end
				default:
					state_r <= PRF_ST_IDLE;
			endcase
		end
	end

	function automatic logic [11:0] prf_min3(input logic [11:0] a, input logic [11:0] b,
		input logic [11:0] c);
		logic [11:0] m;
		m = a < b ? a : b;
		return m < c ? m : c;
	endfunction : prf_min3

	// ****************************************
	// Fragment output
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			frag_r <= '0;
			frag_valid_r <= 1'b0;
		end
		else if (issue)
		begin
			frag_r.x <= cur_x_r;
			frag_r.y <= cur_y_r;
			frag_r.z <= z_out;
			frag_r.f <= f_out;
			frag_r.cov <= !aa_en_r ? `PRF_COV_FULL : (cnt == 0 ? `PRF_COV_MIN : cnt);
			frag_r.front <= front_r;
			frag_valid_r <= 1'b1;
		end
		else if (frag_ready)
			frag_valid_r <= 1'b0;
	end

	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready = w_rdy_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign prim_ready = prim_rdy_r;
	assign frag_out = frag_r;
	assign frag_valid = frag_valid_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	AST_FACING: assert property (state_r == PRF_ST_SETUP |=> last_front_r ==
		($past(wind_cw_r) ? $past(area2) < 0 : $past(area2) > 0))
		else $error("facing does not follow signed area and winding");
	AST_CULL_BOTH: assert property (state_r == PRF_ST_SETUP && cull_en_r &&
		cull_sel_r == PRF_CULL_BOTH |=> state_r == PRF_ST_IDLE && last_culled_r)
		else $error("both-face culling let a polygon through");
	AST_FRONT_KEPT: assert property (state_r == PRF_ST_SETUP && area2 != 0 && front_nxt &&
		(!cull_en_r || cull_sel_r == PRF_CULL_BACK) |=> state_r == PRF_ST_SCAN)
		else $error("front polygon wrongly culled");
	AST_CENTER_ONLY: assert property (issue && !aa_en_r |-> in_ctr)
		else $error("fragment issued with centre outside");
	AST_MASKED: assert property (advance && cover_hit && stip_en_r && !stip_bit |-> !issue)
		else $error("masked fragment issued");
	AST_NO_MASK: assert property (advance && cover_hit && !stip_en_r |-> issue)
		else $error("fragment dropped with masking off");
	AST_FLAT: assert property (issue && prim_r.qual == PRF_Q_FLAT |=>
		frag_valid_r && frag_out.f == $past(prim_r.v[pv].f))
		else $error("flat output differs from provoking vertex");
	AST_EMIT: assert property (issue |=> frag_valid_r && frag_out.x == $past(cur_x_r)
		&& frag_out.y == $past(cur_y_r))
		else $error("issued fragment not presented next cycle");
	AST_WR_RESP: assert property (do_wr |=> s_axi_bvalid ##0 !s_axi_awready [*1])
		else $error("write response missing after address and data");

	COV_CULLED: cover property (state_r == PRF_ST_SETUP && !keep_nxt);
	COV_AA_FRAG: cover property (issue && aa_en_r);
	COV_MASKED: cover property (advance && cover_hit && stip_en_r && !stip_bit);
	COV_FLAT: cover property (issue && prim_r.qual == PRF_Q_FLAT);

endmodule : prf_raster_front_end

// ---- tb/prf_frag_sink.sv ----
// Downstream fragment stage model: refuses one cycle in three, counts taken fragments.
// Assumes the fragment stream runs on sys_clk with a valid/ready handshake.
module prf_frag_sink
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Fragment stream
	input wire prf_pkg::prf_frag_t frag_out,
	input wire logic frag_valid,
	output logic frag_ready,
	// Bench view
	input wire logic clr,
	output logic [7:0] cnt,
	output prf_pkg::prf_frag_t last
);
	timeunit 1ns;
	timeprecision 1ps;
	import prf_pkg::*;
	logic [1:0] ph_r;

	// Regular stalls so the source must hold a fragment across refused cycles
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			ph_r <= 2'h0;
		else
			ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
	assign frag_ready = (ph_r != 2'h2);

	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
			cnt <= 8'h00;
		else if (clr)
			cnt <= 8'h00;
		else if (frag_valid && frag_ready)
			cnt <= cnt + 8'h01;

	always_ff @(posedge sys_clk)
		if (frag_valid && frag_ready)
			last <= frag_out;
endmodule : prf_frag_sink

// ---- tb/tb.sv ----
// Self-checking bench for the raster front end: AXI4-Lite master, triangle source.
// Assumes the fragment sink model stands on the fragment stream.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import prf_pkg::*;
	typedef struct packed {logic [7:0] ctrl; logic cw; logic [7:0] n; logic fr;} prf_row_t;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, prim_valid = 1'b0, clr = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic prim_ready, frag_valid, frag_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd_d;
	logic [7:0] cnt;
	prf_prim_t prim_in = '0;
	prf_qual_t qsel = PRF_Q_FLAT;
	prf_frag_t frag_out, last;
	int miscompares = 0;
	int tests_run = 0;
	// Triangle of legs 4.25 px: 10 centres inside, none on an edge
	prf_row_t rows [10] = '{
		'{8'h08, 1'b0, 8'h0A, 1'b1}, '{8'h08, 1'b1, 8'h0A, 1'b0},
		'{8'h0A, 1'b0, 8'h0A, 1'b1}, '{8'h0A, 1'b1, 8'h00, 1'b0},
		'{8'h06, 1'b0, 8'h00, 1'b1}, '{8'h06, 1'b1, 8'h0A, 1'b0},
		'{8'h0E, 1'b0, 8'h00, 1'b1}, '{8'h0E, 1'b1, 8'h00, 1'b0},
		'{8'h0B, 1'b1, 8'h0A, 1'b1}, '{8'h0B, 1'b0, 8'h00, 1'b0}};

	prf_raster_front_end dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .prim_in, .prim_valid, .prim_ready, .frag_out, .frag_valid,
		.frag_ready);
	prf_frag_sink snk (.sys_clk, .resetn, .frag_out, .frag_valid, .frag_ready, .clr, .cnt, .last);

	initial
		forever #5 sys_clk = ~sys_clk;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic prf_prim_t mk_tri(input logic cw);
		prf_prim_t p;
		p = '0;
		p.qual = qsel;
		p.provoke = 2'h2;
		for (int i = 0; i < 3; i++)
		begin
			p.v[i].w = 16'h0010;
			p.v[i].f = 16'(i + 1) << 8;
			p.v[i].z = 16'(i + 1) << 8;
		end
		p.v[cw ? 2 : 1].x = 16'h0044;
		p.v[cw ? 1 : 2].y = 16'h0044;
		return p;
	endfunction : mk_tri

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic tmo();
		miscompares++;
		close_out();
	endtask : tmo

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) tmo();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) tmo();
	endtask : rd

	// Sends one triangle, then waits for the block to return to idle and drain
	task automatic draw(input logic cw);
		int n;
		@(posedge sys_clk);
		prim_in <= mk_tri(cw);
		prim_valid <= 1'b1;
		clr <= 1'b1;
		for (n = 0; n < 50 && !(prim_valid && prim_ready); n++) @(posedge sys_clk);
		if (n == 50) tmo();
		prim_valid <= 1'b0;
		clr <= 1'b0;
		@(posedge sys_clk);
		for (n = 0; n < 300 && !prim_ready; n++) @(posedge sys_clk);
		if (n == 300) tmo();
		repeat (4) @(posedge sys_clk);
	endtask : draw

	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(8'h00); chk("ctrl reset", 32'h0000_0008, rd_d);
		rd(8'h0C); chk("mask reset", 32'hFFFF_FFFF, rd_d);
		rd(8'h40); chk("unmapped read", 32'h0000_0002, 32'(rsp));
		$display("done reset");
		foreach (rows[i])
		begin
			wr(8'h00, {24'h00_0000, rows[i].ctrl});
			draw(rows[i].cw);
			chk("frag count", 32'(rows[i].n), 32'(cnt));
			rd(8'h04);
			chk("culled flag", 32'(rows[i].n == 8'h00), 32'(rd_d[2]));
			if (rows[i].n != 8'h00)
			begin
				chk("front", 32'(rows[i].fr), 32'(last.front));
				chk("flat attr", 32'h0000_0300, 32'(last.f));
				chk("coverage", 32'h0000_0004, 32'(last.cov));
			end
		end
		$display("done rows");
		wr(8'h08, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0005);
		rd(8'h0C); chk("mask row", 32'h0000_0005, rd_d);
		wr(8'h00, 32'h0000_0018);
		draw(1'b0); chk("masked count", 32'h0000_0008, 32'(cnt));
		wr(8'h00, 32'h0000_0008);
		draw(1'b0); chk("unmasked count", 32'h0000_000A, 32'(cnt));
		wr(8'h10, 32'h0000_0001); chk("unmapped write", 32'h0000_0002, 32'(rsp));
		rd(8'h00); chk("ctrl kept", 32'h0000_0008, rd_d);
		wr(8'h00, 32'h0000_0028);
		draw(1'b0); chk("aa count", 32'h0000_000F, 32'(cnt));
		$display("done mask and antialias");
		// Last fragment sits at pixel (0,3): weights 4, 8 and 56 of 68
		wr(8'h00, 32'h0000_0008);
		qsel = PRF_Q_LINEAR;
		draw(1'b0);
		chk("last pos", 32'h0000_0003, 32'({last.x, last.y}));
		chk("linear attr", 32'h0000_02C3, 32'(last.f));
		chk("depth", 32'h0000_02C3, 32'(last.z));
		qsel = PRF_Q_PERSP;
		draw(1'b0);
		chk("persp attr", 32'h0000_02C3, 32'(last.f));
		$display("done attributes");
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(8'h00);
		chk("ctrl after reset", 32'h0000_0008, rd_d);
		rd(8'h0C);
		chk("mask after reset", 32'hFFFF_FFFF, rd_d);
		$display("done second reset");
		close_out();
	end
endmodule : tb
